// ### hw/flash_regs.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module flash_regs (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic CMD_COMPLETE,
    output logic CMD_LAUNCH,
    input wire logic SINGLE_FAULT,
    input wire logic DOUBLE_FAULT,
    input wire logic ECC_WR,
    input wire logic [2:0] ECC_WR_SEL,
    input wire logic [15:0] ECC_WR_DATA,
    output logic NVM_RD_REQ,
    output logic [23:0] NVM_RD_ADDR,
    input wire logic NVM_RD_VALID,
    input wire logic [15:0] NVM_RD_DATA,
    input wire logic NVM_RD_DFAULT,
    output logic [15:0] DATAFLASH_PARTITION,
    output logic [15:0] BUFRAM_PARTITION,
    output logic INIT_DONE_OUT,
    output logic [6:0] CLOCK_DIV,
    output logic CMD_IRQ,
    output logic ERR_IRQ,
    output logic FORCE_DOUBLE,
    output logic FORCE_SINGLE
);
    import flash_regs_pkg::*;

    logic [7:0] clock_divider, next_clock_divider;
    logic [7:0] security_config, next_security_config;
    logic [2:0] cmd_word_sel, next_cmd_word_sel;
    logic [2:0] ecc_word_sel, next_ecc_word_sel;
    logic [7:0] module_config, next_module_config;
    logic [7:0] error_interrupt_config, next_error_interrupt_config;
    logic cmd_done_flag, next_cmd_done_flag;
    logic single_flag, next_single_flag;
    logic double_flag, next_double_flag;
    logic pready, next_pready;
    logic [31:0] prdata, next_prdata;
    logic pslverr, next_pslverr;
    logic launch, next_launch;
    logic cmd_irq, next_cmd_irq;
    logic err_irq, next_err_irq;

    init_state_t state, next_state;
    logic field, next_field;
    logic dup, next_dup;
    logic nv_req, next_nv_req;
    logic [23:0] nv_addr, next_nv_addr;
    logic [15:0] df_part, next_df_part;
    logic [15:0] br_part, next_br_part;
    logic init_done, next_init_done;

    logic [9:0] index;
    logic mapped;
    logic wr_ok;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    word_array_if cmd_port ();
    word_array_if ecc_port ();

    word_array command_object_array (
        .clk(CLK_SYS),
        .rst(RST),
        .port(cmd_port.store)
    );

    word_array ecc_result_array (
        .clk(CLK_SYS),
        .rst(RST),
        .port(ecc_port.store)
    );

    function automatic logic hit(input logic [9:0] idx);
        return wr_ok && (index == idx);
    endfunction

    // Word-aligned only; misaligned or out-of-span addresses answer with an error
    assign index = PADDR[11:2];
    assign mapped = (PADDR[1:0] == 2'b00) && (index <= IDX_LAST);
    // A write lands at the edge where pready is seen high, byte lane 0 only
    assign wr_ok = PSEL && PENABLE && pready && PWRITE && mapped && PSTRB[0];
    assign wbyte = PWDATA[7:0];

    // Array ports follow the live index register, so a new index counts at once
    assign cmd_port.sel = cmd_word_sel;
    assign cmd_port.wr_be = {hit(IDX_CMD_OBJ_HI), hit(IDX_CMD_OBJ_LO)};
    assign cmd_port.wdata = {wbyte, wbyte};
    // Software cannot write the result array; only the controller fills it
    assign ecc_port.sel = ECC_WR ? ECC_WR_SEL : ecc_word_sel;
    assign ecc_port.wr_be = {ECC_WR, ECC_WR};
    assign ecc_port.wdata = ECC_WR_DATA;

    always_comb begin
        unique case (index)
            IDX_CLOCK_DIVIDER: rbyte = clock_divider;
            IDX_SECURITY_CONFIG: rbyte = security_config;
            IDX_COMMAND_OBJECT_INDEX: rbyte = {5'h00, cmd_word_sel};
            IDX_ECC_ERROR_INDEX: rbyte = {5'h00, ecc_word_sel};
            IDX_MODULE_CONFIG: rbyte = module_config;
            IDX_ERROR_INTERRUPT_CONFIG: rbyte = error_interrupt_config;
            IDX_MODULE_STATUS: rbyte = {cmd_done_flag, 6'h00, init_done};
            IDX_ERROR_STATUS: rbyte = {6'h00, double_flag, single_flag};
            IDX_CMD_OBJ_HI: rbyte = cmd_port.rdata[15:8];
            IDX_CMD_OBJ_LO: rbyte = cmd_port.rdata[7:0];
            IDX_ECC_RES_HI: rbyte = ecc_port.rdata[15:8];
            IDX_ECC_RES_LO: rbyte = ecc_port.rdata[7:0];
            IDX_DF_PART_HI: rbyte = df_part[15:8];
            IDX_DF_PART_LO: rbyte = df_part[7:0];
            IDX_BR_PART_HI: rbyte = br_part[15:8];
            IDX_BR_PART_LO: rbyte = br_part[7:0];
            default: rbyte = 8'h00;
        endcase
    end

    // Bus answer: one wait cycle so the answer comes from flip-flops
    always_comb begin
        next_pready = PSEL && PENABLE && !pready;
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (PSEL && PENABLE && !pready) begin
            next_pslverr = !mapped;
            if (!PWRITE && mapped) begin
                next_prdata = {24'h000000, rbyte};
            end
        end
    end

    // Control registers; unwritable bits are masked off on every write, except the divider's loaded bit, which every write sets
    always_comb begin
        next_clock_divider = clock_divider;
        next_security_config = security_config;
        next_cmd_word_sel = cmd_word_sel;
        next_ecc_word_sel = ecc_word_sel;
        next_module_config = module_config;
        next_error_interrupt_config = error_interrupt_config;
        if (hit(IDX_CLOCK_DIVIDER)) begin
            next_clock_divider = (wbyte & DIVIDER_MASK) | (8'h01 << DIVIDER_LOADED_BIT);
        end
        if (hit(IDX_SECURITY_CONFIG)) begin
            next_security_config = wbyte;
        end
        if (hit(IDX_COMMAND_OBJECT_INDEX)) begin
            next_cmd_word_sel = wbyte[2:0] & INDEX_MASK[2:0];
        end
        if (hit(IDX_ECC_ERROR_INDEX)) begin
            next_ecc_word_sel = wbyte[2:0] & INDEX_MASK[2:0];
        end
        if (hit(IDX_MODULE_CONFIG)) begin
            next_module_config = wbyte & MODULE_CONFIG_MASK;
        end
        if (hit(IDX_ERROR_INTERRUPT_CONFIG)) begin
            next_error_interrupt_config = wbyte & ERR_IRQ_CONFIG_MASK;
        end
    end

    // Flags: write one to clear, a hardware set in the same cycle wins
    always_comb begin
        logic clr_done;
        logic set_single;
        clr_done = hit(IDX_MODULE_STATUS) && wbyte[CMD_DONE_FLAG_BIT];
        set_single = SINGLE_FAULT && !module_config[IGNORE_SINGLE_FAULT_BIT];
        // Clearing the done flag launches a command; ignored while one runs
        next_launch = clr_done && cmd_done_flag;
        next_cmd_done_flag = (cmd_done_flag && !clr_done) || CMD_COMPLETE;
        next_single_flag = (single_flag
            && !(hit(IDX_ERROR_STATUS) && wbyte[SINGLE_FAULT_BIT])) || set_single;
        next_double_flag = (double_flag
            && !(hit(IDX_ERROR_STATUS) && wbyte[DOUBLE_FAULT_BIT])) || DOUBLE_FAULT;
        next_cmd_irq = next_cmd_done_flag
            && next_module_config[CMD_DONE_IRQ_EN_BIT];
        next_err_irq = (next_single_flag && next_error_interrupt_config[SINGLE_FAULT_BIT])
            || (next_double_flag && next_error_interrupt_config[DOUBLE_FAULT_BIT]);
    end

    // Partition fields are fetched once after reset, duplicate on double fault
    always_comb begin
        next_state = state;
        next_field = field;
        next_dup = dup;
        next_nv_req = 1'b0;
        next_nv_addr = nv_addr;
        next_df_part = df_part;
        next_br_part = br_part;
        unique case (state)
            INIT_REQ: begin
                next_nv_req = 1'b1;
                next_nv_addr = (field ? NV_BUFRAM_PART_ADDR : NV_DATAFLASH_PART_ADDR)
                    + (dup ? NV_DUPLICATE_OFFSET : 24'h000000);
                next_state = INIT_WAIT;
            end
            INIT_WAIT: begin
                if (NVM_RD_VALID) begin
                    if (NVM_RD_DFAULT && !dup) begin
                        next_dup = 1'b1;
                        next_state = INIT_REQ;
                    end else begin
                        if (field) begin
                            next_br_part = NVM_RD_DATA;
                            next_state = INIT_DONE;
                        end else begin
                            next_df_part = NVM_RD_DATA;
                            next_field = 1'b1;
                            next_dup = 1'b0;
                            next_state = INIT_REQ;
                        end
                    end
                end
            end
            INIT_DONE: begin
                next_state = INIT_DONE;
            end
        endcase
        // Registered so the pin never carries decode glitches of the state
        next_init_done = (next_state == INIT_DONE);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            clock_divider <= CLOCK_DIVIDER_RESET;
            security_config <= SECURITY_CONFIG_RESET;
            cmd_word_sel <= INDEX_RESET;
            ecc_word_sel <= INDEX_RESET;
            module_config <= MODULE_CONFIG_RESET;
            error_interrupt_config <= ERR_IRQ_CONFIG_RESET;
            cmd_done_flag <= 1'b1;
            single_flag <= 1'b0;
            double_flag <= 1'b0;
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            launch <= 1'b0;
            cmd_irq <= 1'b0;
            err_irq <= 1'b0;
            state <= INIT_REQ;
            field <= 1'b0;
            dup <= 1'b0;
            nv_req <= 1'b0;
            nv_addr <= 24'h000000;
            df_part <= PARTITION_RESET;
            br_part <= PARTITION_RESET;
            init_done <= 1'b0;
        end else begin
            clock_divider <= next_clock_divider;
            security_config <= next_security_config;
            cmd_word_sel <= next_cmd_word_sel;
            ecc_word_sel <= next_ecc_word_sel;
            module_config <= next_module_config;
            error_interrupt_config <= next_error_interrupt_config;
            cmd_done_flag <= next_cmd_done_flag;
            single_flag <= next_single_flag;
            double_flag <= next_double_flag;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            launch <= next_launch;
            cmd_irq <= next_cmd_irq;
            err_irq <= next_err_irq;
            state <= next_state;
            field <= next_field;
            dup <= next_dup;
            nv_req <= next_nv_req;
            nv_addr <= next_nv_addr;
            df_part <= next_df_part;
            br_part <= next_br_part;
            init_done <= next_init_done;
        end
    end

    assign PREADY = pready;
    assign PRDATA = prdata;
    assign PSLVERR = pslverr;
    assign CMD_LAUNCH = launch;
    assign NVM_RD_REQ = nv_req;
    assign NVM_RD_ADDR = nv_addr;
    assign DATAFLASH_PARTITION = df_part;
    assign BUFRAM_PARTITION = br_part;
    assign INIT_DONE_OUT = init_done;
    assign CLOCK_DIV = clock_divider[6:0];
    assign CMD_IRQ = cmd_irq;
    assign ERR_IRQ = err_irq;
    assign FORCE_DOUBLE = module_config[FORCE_DOUBLE_FAULT_BIT];
    assign FORCE_SINGLE = module_config[FORCE_SINGLE_FAULT_BIT];
endmodule

// ### inc/flash_regs_pkg.sv
package flash_regs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CLOCK_DIVIDER = 10'h000;
    localparam logic [9:0] IDX_SECURITY_CONFIG = 10'h001;
    localparam logic [9:0] IDX_COMMAND_OBJECT_INDEX = 10'h002;
    localparam logic [9:0] IDX_ECC_ERROR_INDEX = 10'h003;
    localparam logic [9:0] IDX_MODULE_CONFIG = 10'h004;
    localparam logic [9:0] IDX_ERROR_INTERRUPT_CONFIG = 10'h005;
    localparam logic [9:0] IDX_MODULE_STATUS = 10'h006;
    localparam logic [9:0] IDX_ERROR_STATUS = 10'h007;
    localparam logic [9:0] IDX_CMD_OBJ_HI = 10'h00a;
    localparam logic [9:0] IDX_CMD_OBJ_LO = 10'h00b;
    localparam logic [9:0] IDX_ECC_RES_HI = 10'h00c;
    localparam logic [9:0] IDX_ECC_RES_LO = 10'h00d;
    localparam logic [9:0] IDX_DF_PART_HI = 10'h010;
    localparam logic [9:0] IDX_DF_PART_LO = 10'h011;
    localparam logic [9:0] IDX_BR_PART_HI = 10'h012;
    localparam logic [9:0] IDX_BR_PART_LO = 10'h013;
    localparam logic [9:0] IDX_LAST = 10'h013;

    // Field positions
    localparam int CMD_DONE_IRQ_EN_BIT = 7;
    localparam int IGNORE_SINGLE_FAULT_BIT = 4;
    localparam int FORCE_DOUBLE_FAULT_BIT = 1;
    localparam int FORCE_SINGLE_FAULT_BIT = 0;
    localparam int CMD_DONE_FLAG_BIT = 7;
    localparam int INIT_DONE_BIT = 0;
    localparam int DOUBLE_FAULT_BIT = 1;
    localparam int SINGLE_FAULT_BIT = 0;
    localparam int DIVIDER_LOADED_BIT = 7;

    // Writable bit masks
    localparam logic [7:0] MODULE_CONFIG_MASK = 8'h93;
    localparam logic [7:0] ERR_IRQ_CONFIG_MASK = 8'hdf;
    localparam logic [7:0] INDEX_MASK = 8'h07;
    localparam logic [7:0] DIVIDER_MASK = 8'h7f;

    // Values after reset
    localparam logic [7:0] CLOCK_DIVIDER_RESET = 8'h00;
    localparam logic [7:0] SECURITY_CONFIG_RESET = 8'h00;
    localparam logic [7:0] MODULE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] ERR_IRQ_CONFIG_RESET = 8'h00;
    localparam logic [2:0] INDEX_RESET = 3'h0;
    localparam logic [15:0] PARTITION_RESET = 16'hffff;

    // Nonvolatile partition fields; the duplicate sits two bytes above
    localparam logic [23:0] NV_DATAFLASH_PART_ADDR = 24'h120000;
    localparam logic [23:0] NV_BUFRAM_PART_ADDR = 24'h120004;
    localparam logic [23:0] NV_DUPLICATE_OFFSET = 24'h000002;

    localparam int ARRAY_WORDS = 8;

    typedef enum logic [1:0] {
        INIT_REQ,
        INIT_WAIT,
        INIT_DONE
    } init_state_t;
endpackage

// ### inc/word_array_if.sv
`timescale 1ns/1ps
interface word_array_if;
    logic [2:0] sel;
    logic [1:0] wr_be;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport owner (output sel, output wr_be, output wdata, input rdata);
    modport store (input sel, input wr_be, input wdata, output rdata);
endinterface

// ### hw/word_array.sv
`timescale 1ns/1ps
module word_array (
    input wire logic clk,
    input wire logic rst,
    word_array_if.store port
);
    import flash_regs_pkg::*;

    logic [15:0] words [ARRAY_WORDS];
    logic [15:0] next_words [ARRAY_WORDS];

    // Read is combinational so a fresh index is seen on the very next access
    assign port.rdata = words[port.sel];

    always_comb begin
        for (int i = 0; i < ARRAY_WORDS; i++) begin
            next_words[i] = words[i];
        end
        if (port.wr_be[1]) begin
            next_words[port.sel][15:8] = port.wdata[15:8];
        end
        if (port.wr_be[0]) begin
            next_words[port.sel][7:0] = port.wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < ARRAY_WORDS; i++) begin
            if (rst) begin
                words[i] <= 16'h0000;
            end else begin
                words[i] <= next_words[i];
            end
        end
    end
endmodule

// ### tb/flash_regs_checker.sv
`timescale 1ns/1ps
module flash_regs_checker (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic CMD_COMPLETE,
    input wire logic CMD_IRQ,
    input wire logic NVM_RD_REQ,
    input wire logic [23:0] NVM_RD_ADDR,
    input wire logic NVM_RD_VALID,
    input wire logic NVM_RD_DFAULT,
    input wire logic INIT_DONE_OUT,
    input wire logic FORCE_DOUBLE,
    input wire logic FORCE_SINGLE
);
    import flash_regs_pkg::*;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    logic wr_done;
    logic rd_done;
    assign wr_done = PSEL && PENABLE && PWRITE && PREADY;
    assign rd_done = PSEL && PENABLE && !PWRITE && PREADY;
    sequence s_prim_fault;
        NVM_RD_VALID && NVM_RD_DFAULT && NVM_RD_ADDR == NV_DATAFLASH_PART_ADDR;
    endsequence
    sequence s_dup_req;
        ##[1:2] NVM_RD_REQ && NVM_RD_ADDR == NV_DATAFLASH_PART_ADDR + NV_DUPLICATE_OFFSET;
    endsequence
    // Flag and enable are internal, so changes are tied to their causes
    a_irq_rise: assert property ($rose(CMD_IRQ) |->
        $past(CMD_COMPLETE) || $past(CMD_COMPLETE, 2) || $past(wr_done) || $past(wr_done, 2))
        else $error("command irq rose without cause");
    a_irq_fall: assert property ($fell(CMD_IRQ) |->
        $past(wr_done) || $past(wr_done, 2) || $past(RST))
        else $error("command irq fell without write");
    a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    a_addr_decode: assert property (PREADY |->
        PSLVERR == (PADDR[1:0] != 2'h0 || PADDR[11:2] > IDX_LAST))
        else $error("decode error flag wrong");
    a_idle_rdata: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    a_cfg_loose: assert property (rd_done && PADDR == 12'h010 |->
        (PRDATA & 32'hffffff6c) == 32'h0)
        else $error("config loose bit set");
    a_idx_loose: assert property (rd_done && (PADDR == 12'h008 || PADDR == 12'h00c) |->
        PRDATA[31:3] == 29'h0)
        else $error("index upper bits set");
    a_force_follow: assert property (wr_done && PADDR == 12'h010 |-> ##2
        FORCE_DOUBLE == $past(PWDATA[1], 2) && FORCE_SINGLE == $past(PWDATA[0], 2))
        else $error("force bits differ from config");
    a_init_start: assert property ($fell(RST) |->
        ##[0:1] NVM_RD_REQ && NVM_RD_ADDR == NV_DATAFLASH_PART_ADDR)
        else $error("no partition fetch after reset");
    a_dup_fetch: assert property (s_prim_fault |-> s_dup_req)
        else $error("duplicate not fetched");
    a_done_after: assert property ($rose(INIT_DONE_OUT) |->
        $past(NVM_RD_VALID) || $past(NVM_RD_VALID, 2))
        else $error("init done without fetch");
endmodule
bind flash_regs flash_regs_checker chk_i (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PREADY, .PRDATA, .PSLVERR, .CMD_COMPLETE, .CMD_IRQ, .NVM_RD_REQ, .NVM_RD_ADDR,
    .NVM_RD_VALID, .NVM_RD_DFAULT, .INIT_DONE_OUT, .FORCE_DOUBLE, .FORCE_SINGLE);

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, q;
    logic cmd_complete = 1'h0, single_fault = 1'h0, double_fault = 1'h0, ecc_wr = 1'h0;
    logic [2:0] ecc_sel = 3'h0;
    logic [15:0] ecc_data = 16'h0, nvm_data = 16'h0, df_part, br_part;
    logic nvm_valid = 1'h0, nvm_dfault = 1'h0, pready, e, nvm_req, init_done;
    logic cmd_irq, err_irq, force_double, force_single, launch;
    logic [6:0] clk_div;
    logic [31:0] prdata;
    logic [23:0] nvm_addr;
    int num_errors = 0, cmp_count = 0, launches = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (launch === 1'h1) begin
            launches++;
        end
    end
    flash_regs dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(e), .CMD_COMPLETE(cmd_complete), .CMD_LAUNCH(launch),
        .SINGLE_FAULT(single_fault),
        .DOUBLE_FAULT(double_fault), .ECC_WR(ecc_wr), .ECC_WR_SEL(ecc_sel),
        .ECC_WR_DATA(ecc_data), .NVM_RD_REQ(nvm_req), .NVM_RD_ADDR(nvm_addr),
        .NVM_RD_VALID(nvm_valid), .NVM_RD_DATA(nvm_data), .NVM_RD_DFAULT(nvm_dfault),
        .DATAFLASH_PARTITION(df_part), .BUFRAM_PARTITION(br_part), .INIT_DONE_OUT(init_done),
        .CLOCK_DIV(clk_div), .CMD_IRQ(cmd_irq), .ERR_IRQ(err_irq), .FORCE_DOUBLE(force_double),
        .FORCE_SINGLE(force_single));
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // Request stands until the edge where ready is seen; the answer is taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        chk({31'h0, pready}, 32'h1, "no ready");
        q = prdata;
        err = e;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic err;
        apb(1'h1, a, d, err);
        chk({31'h0, err}, 32'h0, "write error");
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic err;
        apb(1'h0, a, 8'h0, err);
        chk(q, exp, "read data");
    endtask
    task strobe(input logic [2:0] m);
        @(posedge clk);
        {cmd_complete, single_fault, double_fault} <= m;
        @(posedge clk);
        {cmd_complete, single_fault, double_fault} <= 3'h0;
        repeat (3) @(negedge clk);
    endtask
    task nvm(input logic [23:0] a, input logic f, input logic [15:0] d);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (nvm_req !== 1'h1 && n < 50);
        chk({8'h0, nvm_addr}, {8'h0, a}, "fetch address");
        @(posedge clk);
        nvm_valid <= 1'h1;
        nvm_dfault <= f;
        nvm_data <= d;
        @(posedge clk);
        nvm_valid <= 1'h0;
        nvm_dfault <= 1'h0;
        nvm_data <= ~d;
    endtask
    task t_init;
        nvm(24'h120000, 1'h1, 16'hdead);
        nvm(24'h120002, 1'h0, 16'h1234);
        nvm(24'h120004, 1'h1, 16'hbeef);
        nvm(24'h120006, 1'h0, 16'h0a5c);
        repeat (3) @(negedge clk);
        chk({31'h0, init_done}, 32'h1, "init done");
        chk({df_part, br_part}, 32'h12340a5c, "partitions");
        rd(12'h040, 32'h12);
        rd(12'h04c, 32'h5c);
    endtask
    task t_cfg;
        wr(12'h010, 8'hff);
        rd(12'h010, 32'h93);
        chk({cmd_irq, force_double, force_single}, 32'h7, "config outputs");
        wr(12'h010, 8'h00);
        rd(12'h010, 32'h0);
        chk({cmd_irq, force_double, force_single}, 32'h0, "config outputs");
    endtask
    task t_cmd;
        wr(12'h010, 8'h80);
        wr(12'h018, 8'h80);
        rd(12'h018, 32'h01);
        chk(32'(launches), 32'h1, "launch pulses");
        chk({31'h0, cmd_irq}, 32'h0, "irq while busy");
        strobe(3'h4);
        chk({31'h0, cmd_irq}, 32'h1, "irq after done");
        rd(12'h018, 32'h81);
        wr(12'h010, 8'h00);
    endtask
    task t_fault;
        wr(12'h014, 8'h03);
        wr(12'h010, 8'h10);
        strobe(3'h2);
        rd(12'h01c, 32'h0);
        chk({31'h0, err_irq}, 32'h0, "ignored irq");
        strobe(3'h1);
        rd(12'h01c, 32'h2);
        wr(12'h01c, 8'h02);
        wr(12'h010, 8'h00);
        strobe(3'h2);
        rd(12'h01c, 32'h1);
        chk({31'h0, err_irq}, 32'h1, "single irq");
        wr(12'h01c, 8'h01);
        rd(12'h01c, 32'h0);
    endtask
    task t_index;
        wr(12'h008, 8'hff);
        rd(12'h008, 32'h07);
        wr(12'h00c, 8'hf8);
        rd(12'h00c, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(12'h008, 8'(i));
            wr(12'h028, 8'(8'h10 + i));
            wr(12'h02c, 8'(8'h20 + i));
        end
        // Descending readback so a stale selector cannot match by chance
        for (int i = 7; i >= 0; i--) begin
            wr(12'h008, 8'(i));
            rd(12'h028, 32'(8'h10 + i));
            rd(12'h02c, 32'(8'h20 + i));
        end
    endtask
    task t_ecc;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ecc_wr <= 1'h1;
            ecc_sel <= 3'(i);
            ecc_data <= {8'(8'h40 + i), 8'(8'h50 + i)};
        end
        @(posedge clk);
        ecc_wr <= 1'h0;
        for (int i = 7; i >= 0; i--) begin
            wr(12'h00c, 8'(i));
            rd(12'h030, 32'(8'h40 + i));
            rd(12'h034, 32'(8'h50 + i));
        end
    endtask
    task t_range;
        logic err;
        rd(12'h020, 32'h0);
        apb(1'h0, 12'h050, 8'h0, err);
        chk({err, q[30:0]}, 32'h80000000, "past span");
        apb(1'h1, 12'h011, 8'hff, err);
        chk({31'h0, err}, 32'h1, "misaligned");
        rd(12'h010, 32'h0);
    endtask
    task t_plain;
        wr(12'h000, 8'h25);
        rd(12'h000, 32'ha5);
        chk({25'h0, clk_div}, 32'h25, "divider out");
        wr(12'h004, 8'h5a);
        rd(12'h004, 32'h5a);
    endtask
    task results;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_init;
        t_cfg;
        t_cmd;
        t_fault;
        t_index;
        t_ecc;
        t_range;
        t_plain;
        results;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results;
    end
endmodule
